// *** logic/ext_irq_defs.vh ***
`ifndef EXT_IRQ_DEFS_VH
`define EXT_IRQ_DEFS_VH
// Register indices; byte address is four times the index
`define IDX_PIN_CHANGE_MASK   8'h15
`define IDX_MCU_CONTROL       8'h35
`define IDX_INTERRUPT_FLAGS   8'h3a
`define IDX_INTERRUPT_ENABLES 8'h3b
`define IDX_EVENT_STATUS      8'h40
`define IDX_EVENT_MASK        8'h41
// Field positions
`define BIT_SENSE_SEL_LO      0
`define BIT_SENSE_SEL_HI      1
`define BIT_EXT_IRQ           6
`define BIT_PIN_CHANGE        5
`define PC_MASK_BITS          6
// Reset values
`define RST_BYTE              8'h00
`define RST_EVENTS            2'h0
`define RST_SENSE             2'h0
`define RST_PC_MASK           6'h00
// Sense modes
`define SENSE_LOW             2'h0
`define SENSE_ANY             2'h1
`define SENSE_FALL            2'h2
`define SENSE_RISE            2'h3
`endif

// *** logic/external_pin_interrupt_unit.v ***
// Summary of operation
// R1: Sense field selects low, change, fall, rise
// R2: Pin sampled before edges; longer pulses trigger
// R3: Source holds low level until instruction ends
// R4: External request needs enable and global flag
// R5: Pin activity triggers even when pin outputs
// R6: External interrupt has its own vector
// R7: Masked pin changes cause pin-change interrupt
// R8: Reserved flag and enable bits read zero
// R9: External flag sets on triggering edge
// R10: Flag cleared when its routine is entered
// R11: Write one clears flag, zero keeps it
// R12: Flag reads cleared in low-level mode
// R13: Pin-change flag sets on enabled pin change
// R14: Flag, global and enable vector pin-change
// R15: Per-pin mask bits gate change detection
// R16: Pin changes detectable without running clock
// R17: Low level detected without running clock
// R18: Edge detection needs the running clock
// R19: Request is flag AND enable, gated globally; in low-level mode the sampled pin level stands in for the flag
//
// The Avalon-MM slave port was chosen for this implementation.
`include "ext_irq_defs.vh"
module external_pin_interrupt_unit (
  input  wire        CORE_CLK,
  input  wire        RSTN,
  input  wire [9:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output wire        AVS_WAITREQUEST,
  output reg  [1:0]  AVS_RESPONSE,
  input  wire        EXT_IRQ_PIN,
  input  wire [5:0]  PIN_CHANGE_SOURCES,
  input  wire        GLOBAL_IRQ_ENABLE,
  input  wire        ACK_EXT_IRQ,
  input  wire        ACK_PIN_CHANGE,
  output wire        EXT_IRQ_REQUEST,
  output wire        PIN_CHANGE_REQUEST,
  output wire        EXT_LEVEL_WAKE,
  output wire        PIN_CHANGE_WAKE,
  output wire        IRQ
);

  reg  [1:0] sense_sel;
  reg        ext_irq_enable;
  reg        pin_change_enable;
  reg  [5:0] pin_change_mask;
  reg        ext_irq_flag;
  reg        pin_change_flag;
  reg  [1:0] event_status;
  reg  [1:0] event_mask;
  reg        ext_sync;
  reg        ext_sample;
  reg        ext_prev;
  reg  [5:0] pc_sync;
  reg  [5:0] pc_sample;
  reg  [5:0] pc_prev;
  reg        answered;
  reg  [31:0] next_readdata;
  reg        hit;
  wire       access;
  wire       wr;
  wire [7:0] idx;
  wire [7:0] wbyte;
  reg        edge_hit;
  wire       level_low;
  wire       pc_hit;
  wire [5:0] pc_changed;
  wire       w1c_ext;
  wire       w1c_pc;
  wire       control_write;
  wire       enables_write;
  wire       flags_write;
  wire       mask_write;
  wire       status_write;
  wire       event_mask_write;
  wire       sense_low;
  wire       ext_pending;
  wire       ext_armed;
  wire       pc_armed;
  wire       ext_event;
  wire       pc_event;
  wire [1:0] status_set;
  wire [1:0] status_clear;
  wire [5:0] pc_raw_diff;
  wire [7:0] rd_control;
  wire [7:0] rd_enables;
  wire [7:0] rd_flags;
  wire [7:0] rd_mask;
  wire [7:0] rd_status;
  wire [7:0] rd_evmask;
  reg  [1:0] next_response;

  // One wait state: the answer comes the cycle after the request is seen
  assign access          = (AVS_READ | AVS_WRITE) & ~answered;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~answered;
  assign idx             = AVS_ADDRESS[9:2];
  assign wbyte           = AVS_WRITEDATA[7:0];

  // Writes land on the edge where waitrequest is low, the only edge the master trusts
  assign wr               = AVS_WRITE & answered & AVS_BYTEENABLE[0];
  assign control_write    = wr & (idx == `IDX_MCU_CONTROL);
  assign enables_write    = wr & (idx == `IDX_INTERRUPT_ENABLES);
  assign flags_write      = wr & (idx == `IDX_INTERRUPT_FLAGS);
  assign mask_write       = wr & (idx == `IDX_PIN_CHANGE_MASK);
  assign status_write     = wr & (idx == `IDX_EVENT_STATUS);
  assign event_mask_write = wr & (idx == `IDX_EVENT_MASK);

  // Pin is sampled twice before any comparison; reset to the idle high level
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ext_sync   <= 1'b1;
      ext_sample <= 1'b1;
      ext_prev   <= 1'b1;
    end else begin
      ext_sync   <= EXT_IRQ_PIN; // R5
      ext_sample <= ext_sync; // R2
      ext_prev   <= ext_sample;
    end
  end

  // Pin-change sources take the same path, one bit at a time
  genvar g;
  generate
    for (g = 0; g < `PC_MASK_BITS; g = g + 1) begin : pc_det
      always @(posedge CORE_CLK) begin
        if (!RSTN) begin
          pc_sync[g]   <= 1'b0;
          pc_sample[g] <= 1'b0;
          pc_prev[g]   <= 1'b0;
        end else begin
          pc_sync[g]   <= PIN_CHANGE_SOURCES[g];
          pc_sample[g] <= pc_sync[g];
          pc_prev[g]   <= pc_sample[g];
        end
      end
      assign pc_changed[g]  = (pc_sample[g] ^ pc_prev[g]) & pin_change_mask[g]; // R15
      assign pc_raw_diff[g] = (PIN_CHANGE_SOURCES[g] ^ pc_sample[g]) & pin_change_mask[g];
    end
  endgenerate
  // Any enabled pin that moved
  assign pc_hit = |pc_changed; // R7

  // Sense decode; level mode looks at the sampled pin, not the raw one
  assign sense_low = (sense_sel == `SENSE_LOW);
  assign level_low = ~ext_sample;

  // Edge logic exists only on the clock; it sees nothing while the clock stops
  always @* begin
    edge_hit = 1'b0;
    case (sense_sel)
      `SENSE_ANY: begin
        edge_hit = ext_sample ^ ext_prev; // R18
      end
      `SENSE_FALL: begin
        edge_hit = ext_prev & ~ext_sample;
      end
      `SENSE_RISE: begin
        edge_hit = ~ext_prev & ext_sample;
      end
      default: begin
        edge_hit = 1'b0; // R1
      end
    endcase
  end

  // Wake paths are combinational from the raw pins, so they work with the clock halted
  assign EXT_LEVEL_WAKE  = ext_irq_enable & sense_low & ~EXT_IRQ_PIN; // R17
  assign PIN_CHANGE_WAKE = pin_change_enable & (|pc_raw_diff); // R16

  // Write-one-to-clear strobes for the two flags
  assign w1c_ext = flags_write & wbyte[`BIT_EXT_IRQ];
  assign w1c_pc  = flags_write & wbyte[`BIT_PIN_CHANGE];

  // Flags: a new event wins over a clear in the same cycle
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ext_irq_flag <= 1'b0;
    end else if (sense_low) begin
      ext_irq_flag <= 1'b0; // R12
    end else if (edge_hit) begin
      ext_irq_flag <= 1'b1; // R9
    end else if (ACK_EXT_IRQ | w1c_ext) begin
      ext_irq_flag <= 1'b0; // R10 R11
    end
  end

  // Pin-change flag
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pin_change_flag <= 1'b0;
    end else if (pc_hit) begin
      pin_change_flag <= 1'b1; // R13
    end else if (ACK_PIN_CHANGE | w1c_pc) begin
      pin_change_flag <= 1'b0; // R10 R11
    end
  end

  // Level mode requests straight from the held low level; the source must keep it
  assign ext_pending        = sense_low ? level_low : ext_irq_flag;
  assign ext_armed          = GLOBAL_IRQ_ENABLE & ext_irq_enable; // R4 R19
  assign pc_armed           = GLOBAL_IRQ_ENABLE & pin_change_enable; // R14 R19
  assign EXT_IRQ_REQUEST    = ext_armed & ext_pending; // R3 R6
  assign PIN_CHANGE_REQUEST = pc_armed & pin_change_flag; // R6

  // Sense field
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      sense_sel <= `RST_SENSE;
    end else if (control_write) begin
      sense_sel <= wbyte[`BIT_SENSE_SEL_HI:`BIT_SENSE_SEL_LO]; // R1
    end
  end

  // Enable bits
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ext_irq_enable <= 1'b0;
    end else if (enables_write) begin
      ext_irq_enable <= wbyte[`BIT_EXT_IRQ];
    end
  end

  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pin_change_enable <= 1'b0;
    end else if (enables_write) begin
      pin_change_enable <= wbyte[`BIT_PIN_CHANGE];
    end
  end

  // Per-pin mask
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      pin_change_mask <= `RST_PC_MASK;
    end else if (mask_write) begin
      pin_change_mask <= wbyte[5:0];
    end
  end

  // Bus interrupt mask
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      event_mask <= `RST_EVENTS;
    end else if (event_mask_write) begin
      event_mask <= wbyte[1:0];
    end
  end

  // Sticky event status for the bus interrupt; bit0 external, bit1 pin change
  assign ext_event    = edge_hit | (EXT_LEVEL_WAKE & level_low);
  assign pc_event     = pc_hit;
  assign status_set   = {pc_event, ext_event};
  assign status_clear = status_write ? wbyte[1:0] : 2'h0;

  generate
    for (g = 0; g < 2; g = g + 1) begin : ev_bit
      always @(posedge CORE_CLK) begin
        if (!RSTN) begin
          event_status[g] <= 1'b0;
        end else begin
          event_status[g] <= status_set[g] | (event_status[g] & ~status_clear[g]);
        end
      end
    end
  endgenerate

  // One level output for all unmasked events
  assign IRQ = |(event_status & event_mask);

  // Read views of each register; reserved bits are tied low
  assign rd_control = {6'h00, sense_sel};
  assign rd_enables = {1'b0, ext_irq_enable, pin_change_enable, 5'h00}; // R8
  assign rd_flags   = {1'b0, ext_irq_flag, pin_change_flag, 5'h00}; // R8 R12
  assign rd_mask    = {2'h0, pin_change_mask};
  assign rd_status  = {6'h00, event_status};
  assign rd_evmask  = {6'h00, event_mask};

  // Readback multiplexer
  always @* begin
    next_readdata = 32'h00000000;
    hit = 1'b1;
    case (idx)
      `IDX_MCU_CONTROL: begin
        next_readdata[7:0] = rd_control;
      end
      `IDX_INTERRUPT_ENABLES: begin
        next_readdata[7:0] = rd_enables;
      end
      `IDX_INTERRUPT_FLAGS: begin
        next_readdata[7:0] = rd_flags;
      end
      `IDX_PIN_CHANGE_MASK: begin
        next_readdata[7:0] = rd_mask;
      end
      `IDX_EVENT_STATUS: begin
        next_readdata[7:0] = rd_status;
      end
      `IDX_EVENT_MASK: begin
        next_readdata[7:0] = rd_evmask;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    next_response = hit ? 2'h0 : 2'h2;
  end

  // Answer tracker: high for the one cycle in which waitrequest is low
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      answered <= 1'b0;
    end else begin
      answered <= access;
    end
  end

  // Read data clears on a write, so a stale value never stands as an answer
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h00000000;
    end else if (access & AVS_READ) begin
      AVS_READDATA <= next_readdata;
    end else if (access) begin
      AVS_READDATA <= 32'h00000000;
    end
  end

  // Response stands until the next access is answered
  always @(posedge CORE_CLK) begin
    if (!RSTN) begin
      AVS_RESPONSE <= 2'h0;
    end else if (access) begin
      AVS_RESPONSE <= next_response;
    end
  end

endmodule // external_pin_interrupt_unit

// *** verification/ext_irq_sva.sv ***
module ext_irq_sva (
  input wire        CORE_CLK,
  input wire        RSTN,
  input wire        AVS_READ,
  input wire        AVS_WRITE,
  input wire        AVS_WAITREQUEST,
  input wire [31:0] AVS_READDATA,
  input wire        EXT_IRQ_PIN,
  input wire [5:0]  PIN_CHANGE_SOURCES,
  input wire        GLOBAL_IRQ_ENABLE,
  input wire        ACK_EXT_IRQ,
  input wire        ACK_PIN_CHANGE,
  input wire        EXT_IRQ_REQUEST,
  input wire        PIN_CHANGE_REQUEST,
  input wire        EXT_LEVEL_WAKE,
  input wire        PIN_CHANGE_WAKE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  wait_first_a: assert property ($rose(AVS_READ | AVS_WRITE) |-> AVS_WAITREQUEST) else $error("no wait state");
  one_wait_a: assert property ((AVS_READ | AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST) else $error("late answer");
  global_gate_a: assert property (!GLOBAL_IRQ_ENABLE |-> !EXT_IRQ_REQUEST && !PIN_CHANGE_REQUEST)
    else $error("request without global enable");
  ext_ack_a: assert property ($stable(EXT_IRQ_PIN)[*4] ##0 ACK_EXT_IRQ && EXT_IRQ_PIN |=> !EXT_IRQ_REQUEST)
    else $error("ack left external request");
  pc_ack_a: assert property ($stable(PIN_CHANGE_SOURCES)[*4] ##0 ACK_PIN_CHANGE |=> !PIN_CHANGE_REQUEST)
    else $error("ack left pin-change request");
  pc_wake_a: assert property ($stable(PIN_CHANGE_SOURCES)[*4] |-> !PIN_CHANGE_WAKE) else $error("wake w/o change");
  lvl_wake_a: assert property (EXT_LEVEL_WAKE |-> !EXT_IRQ_PIN) else $error("level wake with pin high");
  rdata_top_a: assert property (AVS_READ && !AVS_WAITREQUEST |=> AVS_READDATA[31:8] == 24'h0)
    else $error("upper read data set");
endmodule // ext_irq_sva

// *** verification/core_vector_model.sv ***
module core_vector_model (
  input wire       clk,
  input wire       req,
  input wire [7:0] lat,
  output logic     ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  initial ack = 1'b0;
  // Vector entry after lat cycles; a large lat models a busy core
  always @(posedge clk) begin
    // Compare with >= so a latency cut short in mid-count still answers at once
    cnt <= (req && !ack && cnt < lat - 8'h01) ? cnt + 8'h01 : 8'h00;
    ack <= req && !ack && cnt >= lat - 8'h01;
  end
endmodule // core_vector_model

// *** verification/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CORE_CLK = 0, RSTN = 0, AVS_READ = 0, AVS_WRITE = 0, EXT_IRQ_PIN = 1, GLOBAL_IRQ_ENABLE = 0;
  logic [9:0]  AVS_ADDRESS = 0;
  logic [31:0] AVS_WRITEDATA = 0, AVS_READDATA;
  logic [3:0]  AVS_BYTEENABLE = 4'hf;
  logic [5:0]  PIN_CHANGE_SOURCES = 0, nv;
  logic [1:0]  AVS_RESPONSE;
  logic [7:0]  lat = 8'hff, rd, m;
  logic        AVS_WAITREQUEST, ACK_EXT_IRQ, ACK_PIN_CHANGE, EXT_IRQ_REQUEST, PIN_CHANGE_REQUEST, IRQ, ep;
  logic        EXT_LEVEL_WAKE, PIN_CHANGE_WAKE;
  logic [7:0]  ri [4] = '{8'h15, 8'h35, 8'h3a, 8'h3b};
  logic [7:0]  rw [4] = '{8'h3f, 8'h03, 8'h00, 8'h60};
  int          fail_count = 0, checks_done = 0;
  external_pin_interrupt_unit i_external_pin_interrupt_unit (.*);
  core_vector_model u_ext (.clk(CORE_CLK), .req(EXT_IRQ_REQUEST), .lat(lat), .ack(ACK_EXT_IRQ));
  core_vector_model u_pc (.clk(CORE_CLK), .req(PIN_CHANGE_REQUEST), .lat(lat), .ack(ACK_PIN_CHANGE));
  always #20 CORE_CLK = ~CORE_CLK;
  task chk(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input logic we, input logic [7:0] idx, wd);
    @(posedge CORE_CLK);
    AVS_READ <= !we;
    AVS_WRITE <= we;
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_WRITEDATA <= {24'h0, wd};
    do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA[7:0];
    AVS_READ <= 0;
    AVS_WRITE <= 0;
  endtask
  task rchk(input logic [7:0] idx, exp);
    acc(0, idx, 8'h00);
    chk(rd, exp);
  endtask
  // Pin held six cycles, beyond the two-flop sampling path
  task step(input logic p);
    @(posedge CORE_CLK);
    EXT_IRQ_PIN <= p;
    repeat (6) @(posedge CORE_CLK);
    #1;
  endtask
  task irq(input logic e);
    @(posedge CORE_CLK);
    #1 chk(IRQ, e);
  endtask
  task end_sim;
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    fail_count++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h4491dd81));
    repeat (12) @(posedge CORE_CLK);
    RSTN <= 1;
    for (int i = 0; i < 4; i++) begin
      rchk(ri[i], 8'h00);
      acc(1, ri[i], 8'hff);
      rchk(ri[i], rw[i]);
    end
    acc(0, 8'h20, 8'h00);
    chk({6'h0, AVS_RESPONSE}, 8'h02);
    chk(rd, 8'h00);
    GLOBAL_IRQ_ENABLE <= 1;
    acc(1, 8'h15, 8'h00);
    acc(1, 8'h3b, 8'h40);
    for (int md = 0; md < 4; md++) begin
      acc(1, 8'h35, 8'(md));
      acc(1, 8'h3a, 8'h60);
      m = (md == 1 || md == 2) ? 8'h40 : 8'h00;
      step(0);
      chk(EXT_IRQ_REQUEST, md != 3);
      acc(1, 8'h3a, 8'h00);
      rchk(8'h3a, m);
      acc(1, 8'h3a, 8'h40);
      rchk(8'h3a, 8'h00);
      step(1);
      chk(EXT_IRQ_REQUEST, md[0]);
      lat = 8'h01;
      repeat (4) @(posedge CORE_CLK);
      #1 chk(EXT_IRQ_REQUEST, 0);
      lat = 8'hff;
    end
    acc(1, 8'h3b, 8'h20);
    for (int k = 0; k < 8; k++) begin
      m = (k == 0) ? 8'h3f : 8'($urandom);
      nv = (k == 0) ? ~PIN_CHANGE_SOURCES : 6'($urandom);
      acc(1, 8'h15, m);
      acc(1, 8'h3a, 8'h20);
      ep = |((nv ^ PIN_CHANGE_SOURCES) & m[5:0]);
      @(posedge CORE_CLK);
      PIN_CHANGE_SOURCES <= nv;
      GLOBAL_IRQ_ENABLE <= k == 0 || 1'($urandom);
      repeat (6) @(posedge CORE_CLK);
      #1 chk(PIN_CHANGE_REQUEST, ep & GLOBAL_IRQ_ENABLE);
      rchk(8'h3a, {2'b0, ep, 5'h0});
      lat = 8'h02;
      repeat (5) @(posedge CORE_CLK);
      #1 chk(PIN_CHANGE_REQUEST, 0);
      lat = 8'hff;
    end
    acc(1, 8'h41, 8'h00);
    irq(0);
    acc(1, 8'h41, 8'h02);
    irq(1);
    acc(1, 8'h40, 8'h03);
    irq(0);
    end_sim;
  end
endmodule // tb
bind external_pin_interrupt_unit ext_irq_sva u_sva (.*);
